// ===== rtl/acs_defs.svh
// Register indices, field positions, reset values and cycle counts of the converter control block
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
// Register indices; the byte address is four times the index
`define ACS_IDX_RES_LO     8'h78
`define ACS_IDX_RES_HI     8'h79
`define ACS_IDX_CTRL_A     8'h7a
`define ACS_IDX_SELECT     8'h7c
// Control register A fields
`define ACS_BIT_ON         7
`define ACS_BIT_START      6
`define ACS_BIT_AUTO       5
`define ACS_BIT_FLAG       4
`define ACS_BIT_IE         3
// Select register fields
`define ACS_SEL_MSB        5
`define ACS_TRIG_LSB       8
`define ACS_TRIG_MSB       10
// Reset values
`define ACS_CTRL_RESET     8'h00
`define ACS_SEL_RESET      6'h00
`define ACS_TRIG_RESET     3'h0
// Converter clock cycles per conversion
`define ACS_FIRST_CYCLES   5'd25
`define ACS_NORMAL_CYCLES  5'd13
// Bus responses
`define ACS_RESP_OKAY      2'h0
`define ACS_RESP_SLVERR    2'h2
`endif

// ===== rtl/acs_pkg.sv
// Types shared by the converter control block
package acs_pkg;
   typedef enum logic [0:0] {
      ACS_ST_IDLE = 1'b0,
      ACS_ST_CONV = 1'b1
   } acs_state_t;

   typedef enum logic [2:0] {
      ACS_KIND_NONE     = 3'b000,
      ACS_KIND_SINGLE   = 3'b001,
      ACS_KIND_DIFF     = 3'b010,
      ACS_KIND_BANDGAP  = 3'b011,
      ACS_KIND_GROUND   = 3'b100,
      ACS_KIND_RESERVED = 3'b101
   } acs_kind_t;

   typedef enum logic [1:0] {
      ACS_GAIN_X1   = 2'b00,
      ACS_GAIN_X10  = 2'b01,
      ACS_GAIN_X200 = 2'b10
   } acs_gain_t;
endpackage : acs_pkg

// ===== rtl/acs_prescaler.sv
// Converter clock prescaler: one tick per division period
`timescale 1ns/1ps
`default_nettype none
module acs_prescaler
   import acs_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_reset_n,
   // Control
   input  wire logic       i_enable,
   input  wire logic [2:0] i_div_sel,
   // Tick
   output logic            o_tick
);
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic       tick_r;
   wire  [6:0] last_w;
   wire        wrap_w;

   // Terminal count for each division code
   function automatic logic [6:0] acs_div_last(input logic [2:0] code);
      case (code)
         3'h0, 3'h1: acs_div_last = 7'h01;
         3'h2:       acs_div_last = 7'h03;
         3'h3:       acs_div_last = 7'h07;
         3'h4:       acs_div_last = 7'h0f;
         3'h5:       acs_div_last = 7'h1f;
         3'h6:       acs_div_last = 7'h3f;
         default:    acs_div_last = 7'h7f;
      endcase
   endfunction : acs_div_last

   // Wrap on >= so a smaller divider chosen mid-count cannot stall the counter
   assign last_w  = acs_div_last(i_div_sel);
   assign wrap_w  = (cnt_r >= last_w);
   assign cnt_nxt = (!i_enable || wrap_w) ? 7'h00 : cnt_r + 7'h01;
   assign o_tick  = tick_r;

   // Counter held at zero while the converter is off
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         cnt_r  <= 7'h00;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= i_enable && wrap_w;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   a_tick_spacing: assert property (tick_r |=> !tick_r)
      else $error("converter clock ticks on two adjacent cycles");
endmodule : acs_prescaler
`default_nettype wire

// ===== rtl/acs_chan_decode.sv
// Decoder for codes 0x1e to 0x3f of the input and gain selection code
`timescale 1ns/1ps
`default_nettype none
module acs_chan_decode
   import acs_pkg::*;
(
   // Code
   input  wire logic [5:0] i_code,
   // Routing
   output acs_kind_t       o_kind,
   output logic      [3:0] o_pos,
   output logic      [3:0] o_neg,
   output acs_gain_t       o_gain
);
   wire [3:0] upper_ch_w = {1'b1, i_code[2:0]};
   wire [3:0] pair_w     = i_code[2] ? 4'ha : 4'h8;

   // Channels 8-15, bandgap, ground, gain pairs and unity pairs
   always_comb begin
      o_kind = ACS_KIND_NONE;
      o_pos  = 4'h0;
      o_neg  = 4'h0;
      o_gain = ACS_GAIN_X1;
      case (i_code[5:3])
         3'b011: begin
            if (i_code[2:0] == 3'b110) o_kind = ACS_KIND_BANDGAP;
            if (i_code[2:0] == 3'b111) o_kind = ACS_KIND_GROUND;
         end
         3'b100: begin
            o_kind = ACS_KIND_SINGLE;
            o_pos  = upper_ch_w;
         end
         3'b101: begin
            o_kind = ACS_KIND_DIFF;
            o_pos  = pair_w | {3'h0, i_code[0]};
            o_neg  = pair_w;
            o_gain = i_code[1] ? ACS_GAIN_X200 : ACS_GAIN_X10;
         end
         3'b110: begin
            o_kind = ACS_KIND_DIFF;
            o_pos  = upper_ch_w;
            o_neg  = 4'h9;
         end
         3'b111: begin
            o_kind = (i_code[2:1] == 2'b11) ? ACS_KIND_RESERVED : ACS_KIND_DIFF;
            o_pos  = (i_code[2:1] == 2'b11) ? 4'h0 : upper_ch_w;
            o_neg  = (i_code[2:1] == 2'b11) ? 4'h0 : 4'ha;
         end
         default: o_kind = ACS_KIND_NONE;
      endcase
   end
endmodule : acs_chan_decode
`default_nettype wire

// ===== rtl/acs_ctrl.sv
// Converter control, status, channel selection and register slave on AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"

module acs_ctrl
   import acs_pkg::*;
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   // AXI4-Lite write address and data
   input  wire logic [11:0] i_axi_awaddr,
   input  wire logic        i_axi_awvalid,
   output logic             o_axi_awready,
   input  wire logic [31:0] i_axi_wdata,
   input  wire logic [3:0]  i_axi_wstrb,
   input  wire logic        i_axi_wvalid,
   output logic             o_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       o_axi_bresp,
   output logic             o_axi_bvalid,
   input  wire logic        i_axi_bready,
   // AXI4-Lite read
   input  wire logic [11:0] i_axi_araddr,
   input  wire logic        i_axi_arvalid,
   output logic             o_axi_arready,
   output logic [31:0]      o_axi_rdata,
   output logic [1:0]       o_axi_rresp,
   output logic             o_axi_rvalid,
   input  wire logic        i_axi_rready,
   // Processor side
   input  wire logic        i_global_irq_en,
   input  wire logic        i_irq_ack,
   output logic             o_irq,
   // Trigger source flags, bit n for trigger code n from 1 to 7; bit 0 is unused
   input  wire logic [7:0]  i_trig_src,
   // Converter core
   input  wire logic [9:0]  i_conv_result,
   output logic             o_conv_power,
   output logic             o_conv_clk,
   output logic             o_conv_sample,
   output logic             o_conv_busy,
   output logic             o_conv_first,
   // Analog multiplexer and gain stage
   output acs_kind_t        o_sel_kind,
   output logic [3:0]       o_sel_pos,
   output logic [3:0]       o_sel_neg,
   output acs_gain_t        o_sel_gain
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   acs_state_t  state_r;
   acs_state_t  state_nxt;
   logic        en_r, ate_r, flag_r, ie_r;
   logic [2:0]  ps_r;
   logic [5:0]  sel_r, active_r;
   logic [2:0]  ts_r;
   logic        first_r, first_nxt;
   logic [4:0]  cnt_r, cnt_nxt, len_r;
   logic        busy_r, prev_src_r, done_d_r, irq_r, sample_r;
   logic [9:0]  res_r;
   logic        lock_r;
   logic        aw_got_r, w_got_r, bvalid_r, rvalid_r, awready_r, wready_r, arready_r;
   logic [7:0]  wr_idx_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0]  wstrb_r;
   logic [1:0]  bresp_r, rresp_r;
   acs_kind_t   kind_r;
   logic [3:0]  pos_r, neg_r;
   acs_gain_t   gain_r;
   acs_kind_t   dec_kind;
   logic [3:0]  dec_pos, dec_neg;
   acs_gain_t   dec_gain;
   logic        tick;

   // Register index from a byte address
   function automatic logic [7:0] acs_index(input logic [11:0] addr);
      acs_index = addr[9:2];
   endfunction : acs_index

   // True for an index that holds a register
   function automatic logic acs_mapped(input logic [7:0] idx);
      acs_mapped = (idx == `ACS_IDX_RES_LO) || (idx == `ACS_IDX_RES_HI) ||
                   (idx == `ACS_IDX_CTRL_A) || (idx == `ACS_IDX_SELECT);
   endfunction : acs_mapped

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshakes: write happens once address and data are both held
   wire aw_hs     = i_axi_awvalid && awready_r;
   wire w_hs      = i_axi_wvalid && wready_r;
   wire rd_do     = i_axi_arvalid && arready_r;
   wire wr_do     = aw_got_r && w_got_r && !bvalid_r;
   wire aw_nxt    = !wr_do && (aw_got_r || aw_hs);
   wire w_nxt     = !wr_do && (w_got_r || w_hs);
   wire bv_nxt    = wr_do || (bvalid_r && !i_axi_bready);
   wire rv_nxt    = rd_do || (rvalid_r && !i_axi_rready);
   wire [7:0] rd_idx = acs_index(i_axi_araddr);

   // Register write strobes; only lane 0 and lane 1 carry bits
   wire wr_ctrl   = wr_do && (wr_idx_r == `ACS_IDX_CTRL_A) && wstrb_r[0];
   wire wr_sel    = wr_do && (wr_idx_r == `ACS_IDX_SELECT) && wstrb_r[0];
   wire wr_trig   = wr_do && (wr_idx_r == `ACS_IDX_SELECT) && wstrb_r[1];
   wire rd_lo     = rd_do && (rd_idx == `ACS_IDX_RES_LO);
   wire rd_hi     = rd_do && (rd_idx == `ACS_IDX_RES_HI);

   ////////////////////////////////////////////////////////////////////////////
   // Conversion control
   wire en_nxt    = wr_ctrl ? wdata_r[`ACS_BIT_ON] : en_r;
   wire en_rise   = !en_r && en_nxt;
   wire idle      = (state_r == ACS_ST_IDLE);
   wire start_wr  = wr_ctrl && wdata_r[`ACS_BIT_START];
   wire trig_src  = (ts_r != 3'h0) && i_trig_src[ts_r];
   wire trig_edge = ate_r && trig_src && !prev_src_r;
   wire free_run  = ate_r && (ts_r == 3'h0) && done_d_r;
   wire start_req = en_nxt && idle && (start_wr || trig_edge || free_run);
   wire last_tick = tick && (cnt_r == len_r - 5'd1);
   wire done      = !idle && en_nxt && last_tick;
   wire flag_clr  = (wr_ctrl && wdata_r[`ACS_BIT_FLAG]) || i_irq_ack;

   // Power-down wins over everything, so clearing enable aborts a conversion
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ACS_ST_IDLE: if (start_req) state_nxt = ACS_ST_CONV;
         ACS_ST_CONV: if (done) state_nxt = ACS_ST_IDLE;
         default:     state_nxt = ACS_ST_IDLE;
      endcase
      if (!en_nxt) state_nxt = ACS_ST_IDLE;
   end

   assign cnt_nxt   = start_req ? 5'd0 : (!idle && tick) ? cnt_r + 5'd1 : cnt_r;
   assign first_nxt = start_req ? 1'b0 : (en_rise ? 1'b1 : first_r);

   // Conversion sequencer
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         state_r <= ACS_ST_IDLE;
         busy_r  <= 1'b0;
         cnt_r   <= 5'd0;
         len_r   <= `ACS_NORMAL_CYCLES;
         first_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         busy_r  <= (state_nxt == ACS_ST_CONV);
         cnt_r   <= cnt_nxt;
         first_r <= first_nxt;
         if (start_req)
            len_r <= (first_r || en_rise) ? `ACS_FIRST_CYCLES : `ACS_NORMAL_CYCLES;
      end
   end

   // Control register; a set of the flag beats a clear in the same cycle
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         {en_r, ate_r, ie_r} <= 3'h0;
         ps_r   <= 3'(`ACS_CTRL_RESET);
         flag_r <= 1'b0;
      end else begin
         en_r <= en_nxt;
         if (wr_ctrl) begin
            ate_r <= wdata_r[`ACS_BIT_AUTO];
            ie_r  <= wdata_r[`ACS_BIT_IE];
            ps_r  <= wdata_r[2:0];
         end
         if (done) flag_r <= 1'b1;
         else if (flag_clr) flag_r <= 1'b0;
      end
   end

   // Selection codes; the active code only follows while idle
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         sel_r      <= `ACS_SEL_RESET;
         ts_r       <= `ACS_TRIG_RESET;
         active_r   <= `ACS_SEL_RESET;
         prev_src_r <= 1'b0;
      end else begin
         if (wr_sel) sel_r <= wdata_r[`ACS_SEL_MSB:0];
         if (wr_trig) ts_r <= wdata_r[`ACS_TRIG_MSB:`ACS_TRIG_LSB];
         if (!busy_r) active_r <= sel_r;
         prev_src_r <= trig_src;
      end
   end

   // Result capture, frozen between low and high byte reads
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         res_r  <= 10'h000;
         lock_r <= 1'b0;
      end else begin
         if (done && !lock_r) res_r <= i_conv_result;
         if (rd_hi) lock_r <= 1'b0;
         else if (rd_lo) lock_r <= 1'b1;
      end
   end

   // Registered outputs toward core, multiplexer and processor
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         done_d_r <= 1'b0;
         irq_r    <= 1'b0;
         sample_r <= 1'b0;
         kind_r   <= ACS_KIND_NONE;
         pos_r    <= 4'h0;
         neg_r    <= 4'h0;
         gain_r   <= ACS_GAIN_X1;
      end else begin
         done_d_r <= done;
         irq_r    <= flag_r && ie_r && i_global_irq_en;
         sample_r <= start_req;
         kind_r   <= dec_kind;
         pos_r    <= dec_pos;
         neg_r    <= dec_neg;
         gain_r   <= dec_gain;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data; a read of the control register shows busy in the start bit
   wire [7:0]  ctrl_rd = {en_r, busy_r, ate_r, flag_r, ie_r, ps_r};
   wire [31:0] rd_word = (rd_idx == `ACS_IDX_CTRL_A) ? {24'h000000, ctrl_rd} :
                         (rd_idx == `ACS_IDX_SELECT) ? {21'h0, ts_r, 2'h0, sel_r} :
                         (rd_idx == `ACS_IDX_RES_LO) ? {24'h000000, res_r[7:0]} :
                         (rd_idx == `ACS_IDX_RES_HI) ? {30'h0, res_r[9:8]} : 32'h00000000;

   // Write channel
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         {aw_got_r, w_got_r, bvalid_r} <= 3'h0;
         {awready_r, wready_r} <= 2'h0;
         wr_idx_r <= 8'h00;
         wdata_r  <= 32'h00000000;
         wstrb_r  <= 4'h0;
         bresp_r  <= `ACS_RESP_OKAY;
      end else begin
         aw_got_r  <= aw_nxt;
         w_got_r   <= w_nxt;
         bvalid_r  <= bv_nxt;
         awready_r <= !aw_nxt && !bv_nxt;
         wready_r  <= !w_nxt && !bv_nxt;
         if (aw_hs) wr_idx_r <= acs_index(i_axi_awaddr);
         if (w_hs) wdata_r <= i_axi_wdata;
         if (w_hs) wstrb_r <= i_axi_wstrb;
         if (wr_do) bresp_r <= acs_mapped(wr_idx_r) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end
   end

   // Read channel
   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b0;
         rdata_r   <= 32'h00000000;
         rresp_r   <= `ACS_RESP_OKAY;
      end else begin
         rvalid_r  <= rv_nxt;
         arready_r <= !rv_nxt;
         if (rd_do) rdata_r <= rd_word;
         if (rd_do) rresp_r <= acs_mapped(rd_idx) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Submodules
   acs_prescaler u_prescaler (
      .i_clk     (i_clk),
      .i_reset_n (i_reset_n),
      .i_enable  (en_r),
      .i_div_sel (ps_r),
      .o_tick    (tick)
   );

   acs_chan_decode u_decode (
      .i_code (active_r),
      .o_kind (dec_kind),
      .o_pos  (dec_pos),
      .o_neg  (dec_neg),
      .o_gain (dec_gain)
   );

   // Port drive
   assign o_axi_awready = awready_r;
   assign o_axi_wready  = wready_r;
   assign o_axi_bvalid  = bvalid_r;
   assign o_axi_bresp   = bresp_r;
   assign o_axi_arready = arready_r;
   assign o_axi_rvalid  = rvalid_r;
   assign o_axi_rdata   = rdata_r;
   assign o_axi_rresp   = rresp_r;
   assign o_irq         = irq_r;
   assign o_conv_power  = en_r;
   assign o_conv_clk    = tick;
   assign o_conv_sample = sample_r;
   assign o_conv_busy   = busy_r;
   assign o_conv_first  = first_r;
   assign o_sel_kind    = kind_r;
   assign o_sel_pos     = pos_r;
   assign o_sel_neg     = neg_r;
   assign o_sel_gain    = gain_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   a_flag_on_done: assert property (done |=> flag_r && !busy_r)
      else $error("flag not set or busy not cleared after completion");
   a_abort_off: assert property (!en_r |-> state_r == ACS_ST_IDLE && !busy_r)
      else $error("converter busy while disabled");
   a_first_long: assert property (start_req && (first_r || en_rise) |=> len_r == 5'd25)
      else $error("first conversion not given the long length");
   a_normal_len: assert property (start_req && !first_r && !en_rise |=> len_r == 5'd13)
      else $error("later conversion not given the normal length");
   a_irq_gate: assert property (o_irq |-> $past(flag_r) && $past(ie_r) && $past(i_global_irq_en))
      else $error("interrupt raised without flag and both enables");
   a_ack_clears: assert property (flag_r && i_irq_ack && !done |=> !flag_r)
      else $error("flag survived an acknowledge");
   a_lock_hold: assert property (lock_r |=> res_r == $past(res_r))
      else $error("result changed while locked");
   a_edge_start: assert property (trig_edge && en_r && idle && !wr_ctrl |=> busy_r && o_conv_sample)
      else $error("trigger edge did not start a conversion");
   a_zero_start: assert property (idle && wr_ctrl && !wdata_r[6] && !trig_edge && !free_run |=> !busy_r)
      else $error("writing zero to start began a conversion");
   a_bandgap_code: assert property (active_r == 6'h1e |=> o_sel_kind == ACS_KIND_BANDGAP)
      else $error("bandgap code not routed");
endmodule : acs_ctrl
`default_nettype wire

// ===== verif/acs_core_model.sv
// Behavioural converter core that hands a fresh result to every sample pulse
`timescale 1ns/1ps
`default_nettype none
module acs_core_model (
   // Clock and control
   input  wire logic       i_clk,
   input  wire logic       i_power,
   input  wire logic       i_sample,
   // Result
   output logic      [9:0] o_result
);
   logic [9:0] val_r = 10'h155;
   // A new value on each sample, so a stale or missed latch shows up
   always_ff @(posedge i_clk) if (i_sample) val_r <= val_r + 10'h0b3;
   // Powered down the core gives garbage, modelled as the inverse
   assign o_result = i_power ? val_r : ~val_r;
endmodule : acs_core_model
`default_nettype wire

// ===== verif/acs_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"
module acs_ctrl_tb;
   import acs_pkg::*;
   localparam logic [11:0] A_LO = 12'(`ACS_IDX_RES_LO * 4);
   localparam logic [11:0] A_HI = 12'(`ACS_IDX_RES_HI * 4);
   localparam logic [11:0] A_CTRL = 12'(`ACS_IDX_CTRL_A * 4);
   localparam logic [11:0] A_SEL = 12'(`ACS_IDX_SELECT * 4);
   logic        clk = '0, reset_n = '0, awv = '0, wv = '0, arv = '0, gie = '0, ack = '0;
   logic        awready, wready, bvalid, arready, rvalid, irq, power, cclk, sample, busy, first;
   logic [1:0]  bresp, rresp, resp;
   logic [3:0]  pos, neg;
   logic [7:0]  trig = '0;
   logic [9:0]  result;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rdat;
   acs_kind_t   kind;
   acs_gain_t   gain;
   int          n_errors = 0, n_checks = 0;
   ////////////////////////////////////////////////////////////////////////////////
   // Bready and rready stay high, so every response is taken at once
   acs_ctrl acs_ctrl_i (
      .i_clk(clk), .i_reset_n(reset_n), .i_axi_awaddr(awaddr), .i_axi_awvalid(awv), .o_axi_awready(awready),
      .i_axi_wdata(wdata), .i_axi_wstrb(4'hf), .i_axi_wvalid(wv), .o_axi_wready(wready), .o_axi_bresp(bresp),
      .o_axi_bvalid(bvalid), .i_axi_bready(1'h1), .i_axi_araddr(araddr), .i_axi_arvalid(arv),
      .o_axi_arready(arready), .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
      .i_axi_rready(1'h1), .i_global_irq_en(gie), .i_irq_ack(ack), .o_irq(irq), .i_trig_src(trig),
      .i_conv_result(result), .o_conv_power(power), .o_conv_clk(cclk), .o_conv_sample(sample),
      .o_conv_busy(busy), .o_conv_first(first), .o_sel_kind(kind), .o_sel_pos(pos), .o_sel_neg(neg),
      .o_sel_gain(gain));
   acs_core_model acs_core_model_i (.i_clk(clk), .i_power(power), .i_sample(sample), .o_result(result));
   initial begin
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Compare, report and close
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic tmo();
      n_errors++;
      conclude();
   endtask : tmo
   // Whole words only: a read-modify-write would clear a pending flag
   task automatic wr(logic [11:0] a, logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      for (int i = 0; i <= 50; i++) begin
         if (i == 50) tmo();
         @(posedge clk);
         if (awready) awv <= 1'h0;
         if (wready) wv <= 1'h0;
         if (bvalid) begin
            resp = bresp;
            return;
         end
      end
   endtask : wr
   task automatic rd(logic [11:0] a);
      araddr <= a;
      arv <= 1'h1;
      for (int i = 0; i <= 50; i++) begin
         if (i == 50) tmo();
         @(posedge clk);
         if (arready) arv <= 1'h0;
         if (rvalid) begin
            rdat = rdata;
            resp = rresp;
            return;
         end
      end
   endtask : rd
   task automatic rdchk(string what, logic [11:0] a, logic [31:0] exp);
      rd(a);
      chk(what, exp, rdat);
   endtask : rdchk
   // Counts converter clocks seen in busy cycles, starting with the cycle that ended at the call's own edge,
   // since a tick right after the start already counts toward the conversion
   task automatic run(output int n);
      n = 0;
      for (int i = 0; i <= 4000; i++) begin
         if (i == 4000) tmo();
         if (busy && cclk) n++;
         if (!busy) return;
         @(posedge clk);
      end
   endtask : run
   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      rdchk("ctrl after reset", A_CTRL, 32'h0);
      chk("power after reset", 32'h0, power);
      wr(12'h100, 32'hff);
      chk("bresp unmapped", `ACS_RESP_SLVERR, resp);
      rdchk("rdata unmapped", 12'h100, 32'h0);
      chk("rresp unmapped", `ACS_RESP_SLVERR, resp);
   endtask : t_reset
   // Routing as {kind, pos, neg, gain}, masked to the fields that mean something
   task automatic t_decode();
      logic [5:0]  cd [9] = '{6'h20, 6'h27, 6'h1e, 6'h1f, 6'h3e, 6'h2b, 6'h2c, 6'h3d, 6'h30};
      logic [12:0] ex [9] = '{13'h0600, 13'h07c0, 13'h0c00, 13'h1000, 13'h1400, 13'h0a62, 13'h0aa9, 13'h0b68,
                              13'h0a24};
      logic [12:0] mk [9] = '{13'h1fc0, 13'h1fc0, 13'h1c00, 13'h1c00, 13'h1c00, 13'h1fff, 13'h1fff, 13'h1fff,
                              13'h1fff};
      for (int i = 0; i < 9; i++) begin
         wr(A_SEL, {26'h0, cd[i]});
         repeat (3) @(posedge clk);
         chk("routing", ex[i], {kind, pos, neg, gain} & mk[i]);
      end
   endtask : t_decode
   // Spacing of converter clock pulses per divider code; each run is aborted early
   task automatic t_divider();
      int divs [8] = '{2, 2, 4, 8, 16, 32, 64, 128};
      int p;
      for (int c = 0; c < 8; c++) begin
         wr(A_CTRL, 32'hc0 | c);
         p = 0;
         for (int i = 0; i <= 600; i++) begin
            if (i == 600) tmo();
            @(posedge clk);
            if (cclk && p > 0) break;
            if (p > 0 || cclk) p++;
         end
         chk("divider", divs[c], p);
         wr(A_CTRL, 32'h0);
      end
   endtask : t_divider
   task automatic t_convert();
      int n;
      gie <= 1'h1;
      wr(A_CTRL, 32'hc8);
      run(n);
      chk("first length", 25, n);
      repeat (2) @(posedge clk);
      chk("irq", 32'h1, irq);
      rdchk("flag set", A_CTRL, 32'h98);
      rdchk("result low", A_LO, {24'h0, result[7:0]});
      rdchk("result high", A_HI, {30'h0, result[9:8]});
      wr(A_CTRL, 32'h88);
      rdchk("flag kept", A_CTRL, 32'h98);
      gie <= 1'h0;
      repeat (3) @(posedge clk);
      chk("irq masked", 32'h0, irq);
      wr(A_CTRL, 32'h98);
      rdchk("flag cleared", A_CTRL, 32'h88);
      wr(A_CTRL, 32'hc8);
      run(n);
      chk("later length", 13, n);
      ack <= 1'h1;
      @(posedge clk);
      ack <= 1'h0;
      rdchk("flag acked", A_CTRL, 32'h88);
   endtask : t_convert
   task automatic t_abort();
      wr(A_CTRL, 32'hc0);
      rdchk("busy read", A_CTRL, 32'hc0);
      wr(A_SEL, 32'h20);
      repeat (2) @(posedge clk);
      chk("code held", ACS_KIND_DIFF, kind);
      wr(A_CTRL, 32'h0);
      @(posedge clk);
      chk("aborted", 32'h0, {power, busy});
      repeat (60) @(posedge clk);
      rdchk("no flag", A_CTRL, 32'h0);
      chk("code applied", ACS_KIND_SINGLE, kind);
   endtask : t_abort
   task automatic t_trigger();
      int n;
      wr(A_SEL, 32'h200);
      wr(A_CTRL, 32'ha0);
      repeat (4) @(posedge clk);
      chk("no trigger", 32'h0, busy);
      chk("first pending", 32'h1, first);
      trig <= 8'h04;
      repeat (3) @(posedge clk);
      chk("triggered", 32'h1, busy);
      chk("first used", 32'h0, first);
      run(n);
      repeat (4) @(posedge clk);
      chk("held level", 32'h0, busy);
      trig <= 8'h08;
      wr(A_SEL, 32'h300);
      repeat (3) @(posedge clk);
      chk("source switch", 32'h1, busy);
      run(n);
      wr(A_SEL, 32'h0);
      repeat (3) @(posedge clk);
      chk("no free run trigger", 32'h0, busy);
      wr(A_CTRL, 32'he0);
      run(n);
      repeat (3) @(posedge clk);
      chk("free run restart", 32'h1, busy);
   endtask : t_trigger
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'h1;
      repeat (2) @(posedge clk);
      t_reset();
      t_decode();
      t_divider();
      t_convert();
      t_abort();
      t_trigger();
      conclude();
   end
endmodule : acs_ctrl_tb
`default_nettype wire
